// >>> tb/peb_dev_model.sv
// Behavioural model of the byte-wide parallel EEPROM on the host pins
`timescale 1ns/100ps
module peb_dev_model
  import peb_pkg::*;
#(
  parameter int PROG_NS = 40000,  // Short self-timed program, inside the limit
  parameter int LOADWIN_NS = 150000  // Byte load window
)(
  // Pins from the host
  input  wire peb_pkg::peb_pins_t       pins_in,
  // Data lines and protocol fault count
  output logic [peb_pkg::DATA_W-1:0]    data_out,
  output int                            errs_out
);
  logic [7:0]  mem [8192];           // Array, starts erased
  logic [7:0]  pbuf [64];            // Page latches
  logic [63:0] pval = '0;            // Latches loaded
  logic [6:0]  pg;                   // Open page
  logic [12:0] alat;                 // Captured address
  logic [7:0]  lastd = 8'h00;        // Last byte written
  logic [7:0]  held = 8'h00;         // Last value driven
  logic        busy = 1'b0;          // Programming
  logic        loading = 1'b0;       // Page load open
  logic        tog = 1'b0;           // Toggling status
  time         ldt = 0;              // Time of last load
  wire         ce_n = pins_in.chip_select_n;
  wire         wr = !ce_n && !pins_in.write_strobe_n && pins_in.output_gate_n && !pins_in.output_gate_hv;
  wire         rd = !ce_n && !pins_in.output_gate_n && pins_in.write_strobe_n && !pins_in.output_gate_hv;
  initial begin
    errs_out = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // Address on the later falling strobe; page and busy faults counted
  always @(posedge wr) begin
    if (busy || (loading && pins_in.addr[12:6] !== pg)) errs_out++;
    if (!loading) pg = pins_in.addr[12:6];
    alat = pins_in.addr;
  end
  // Data on the earlier rising strobe; writes while busy are ignored
  always @(negedge wr) if (!busy && pins_in.data_oe === 1'b1) begin
    pbuf[alat[5:0]] = pins_in.data;
    pval[alat[5:0]] = 1'b1;
    lastd = pins_in.data;
    loading = 1'b1;
    ldt = $time;
  end
  // Output gate must not fall inside a write pulse
  always @(negedge pins_in.output_gate_n) if (!ce_n && !pins_in.write_strobe_n) errs_out++;
  // Load closes when the window lapses
  always #1000 if (loading && $time - ldt > LOADWIN_NS) begin loading = 1'b0; busy = 1'b1; end
  // A read closes an open load and flips the toggling bit
  always @(posedge rd) begin
    if (loading) begin loading = 1'b0; busy = 1'b1; end
    tog = ~tog;
  end
  // Self-timed programming of loaded bytes only
  always @(posedge busy) begin
    #PROG_NS;
    for (int i = 0; i < 64; i++) if (pval[i]) mem[{pg, i[5:0]}] = pbuf[i];
    pval = '0;
    busy = 1'b0;
  end
  // Bus; a floating line shows the inverse so stale data cannot pass
  always @* begin
    if (pins_in.data_oe === 1'b1) data_out = pins_in.data;
    else if (rd) data_out = busy ? {~lastd[7], tog, lastd[5:0]} : mem[pins_in.addr];
    else data_out = ~held;
  end
  always @(data_out) if (rd) held = data_out;
endmodule : peb_dev_model

// >>> tb/testbench.sv
// Self-checking bench for the parallel EEPROM host controller
`timescale 1ns/100ps
module testbench;
  import peb_pkg::*;
  logic              clk_in = 1'b0, nrst_in = 1'b0, req_valid_in = 1'b0;
  peb_req_t          req_in = '0;
  logic              req_ready_out, rd_valid_out, busy_out, page_err_out;
  logic [DATA_W-1:0] rd_data_out, data_in;
  peb_pins_t         pins_out;
  int                dev_errs, failures = 0, checks = 0, seed = 79510, perr = 0;
  logic [7:0]        expq [$];   // Expected read data, oldest first
  logic [7:0]        d [4];
  logic [6:0]        pg;
  always #20 clk_in = ~clk_in;
  peb_host u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .busy_out(busy_out), .page_err_out(page_err_out), .pins_out(pins_out), .data_in(data_in));
  peb_dev_model u_dev (.pins_in(pins_out), .data_out(data_in), .errs_out(dev_errs));
  // Any mismatch counted and shown at once
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Request held until taken; called just after a rising edge
  task send(input peb_cmd_t c, input logic [12:0] a, input logic [7:0] v, input logic l);
    req_in <= '{c, a, v, l};
    req_valid_in <= 1'b1;
    for (int i = 0; i < 300000; i++) begin
      @(negedge clk_in);
      if (req_ready_out === 1'b1) break;
    end
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    @(posedge clk_in); // Let an edge pass before the next request
  endtask : send
  // Wait, bounded, until nothing but an open page load is in progress
  task idle;
    for (int i = 0; i < 300000; i++) begin
      @(negedge clk_in);
      if (busy_out === 1'b0 && req_ready_out === 1'b1) break;
    end
    @(posedge clk_in);
  endtask : idle
  task rd(input logic [12:0] a, input logic [7:0] e);
    expq.push_back(e);
    send(PEB_CMD_READ, a, 8'h00, 1'b0);
  endtask : rd
  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Result watcher takes the oldest note per read
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1) cmp(rd_data_out, expq.size() ? expq.pop_front() : 8'hxx);
    if (page_err_out === 1'b1) perr++;
  end
  // Pins idle and request side ready
  task chk_idle;
    @(negedge clk_in);
    cmp({pins_out.chip_select_n, pins_out.output_gate_n, pins_out.write_strobe_n, pins_out.output_gate_hv,
      pins_out.data_oe, req_ready_out}, 16'h0039);
    @(posedge clk_in);
  endtask : chk_idle
  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk_idle();
    $display("test reset done");
    // Page load out of order with an overwrite
    pg = $random(seed);
    foreach (d[i]) d[i] = $random(seed);
    send(PEB_CMD_WRITE, {pg, 6'h05}, d[0], 1'b0);
    repeat (3) @(negedge clk_in);
    cmp({pins_out.chip_select_n, pins_out.output_gate_n, pins_out.write_strobe_n, pins_out.data_oe,
      pins_out.addr[5:0], pins_out.data}, {4'h5, 6'h05, d[0]});
    @(posedge clk_in);
    send(PEB_CMD_WRITE, {pg, 6'h3F}, d[1], 1'b0);
    send(PEB_CMD_WRITE, {pg, 6'h05}, d[2], 1'b0);
    send(PEB_CMD_WRITE, {pg, 6'h01}, d[3], 1'b1);
    idle();
    rd({pg, 6'h01}, d[3]);
    rd({pg, 6'h05}, d[2]);
    rd({pg, 6'h3F}, d[1]);
    rd({pg, 6'h00}, 8'hFF);
    idle();
    $display("test page write done");
    // Write to a second page while one is open is refused
    send(PEB_CMD_WRITE, {pg + 7'h01, 6'h02}, d[0], 1'b0);
    send(PEB_CMD_WRITE, {pg + 7'h02, 6'h02}, d[1], 1'b0);
    send(PEB_CMD_WRITE, {pg + 7'h01, 6'h03}, d[2], 1'b1);
    idle();
    rd({pg + 7'h01, 6'h02}, d[0]);
    rd({pg + 7'h01, 6'h03}, d[2]);
    rd({pg + 7'h02, 6'h02}, 8'hFF);
    idle();
    $display("test page refusal done");
    // Open page left to lapse starts programming on its own
    send(PEB_CMD_WRITE, {pg + 7'h03, 6'h07}, d[3], 1'b0);
    repeat (LOADWIN_CYC + 10) @(posedge clk_in);
    idle();
    rd({pg + 7'h03, 6'h07}, d[3]);
    send(PEB_CMD_POLL, {pg + 7'h03, 6'h07}, 8'h00, 1'b0);
    expq.push_back(d[3]);
    idle();
    $display("test load window done");
    // Erase pins, then a reset in mid erase
    send(PEB_CMD_ERASE, 13'h0000, 8'h00, 1'b1);
    repeat (30) @(negedge clk_in);
    cmp({pins_out.chip_select_n, pins_out.output_gate_hv, pins_out.write_strobe_n, pins_out.data_oe,
      busy_out}, 16'h0009);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk_idle();
    $display("test erase and reset done");
    cmp(16'(expq.size()), 16'h0000);
    cmp(16'(perr), 16'h0001);
    cmp(16'(dev_errs), 16'h0000);
    results();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk_in);
    failures++;
    results();
  end
endmodule : testbench

// >>> verilog/peb_host.sv
// Host controller that drives the parallel EEPROM through its strobes
`timescale 1ns/100ps
module peb_host
  import peb_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  // Request side
  input  wire peb_pkg::peb_req_t      req_in,
  input  wire logic                   req_valid_in,
  output logic                        req_ready_out,
  output logic [peb_pkg::DATA_W-1:0]  rd_data_out,
  output logic                        rd_valid_out,
  output logic                        busy_out,
  output logic                        page_err_out,
  // Device pins
  output peb_pkg::peb_pins_t          pins_out,
  input  wire logic [peb_pkg::DATA_W-1:0] data_in
);
  import peb_pkg::*;

  // Gray-coded states along the usual path
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_SETUP = 4'h1,
    S_STRB  = 4'h3,
    S_REL   = 4'h2,
    S_LOAD  = 4'h6,
    S_PROG  = 4'h7,
    S_POLL  = 4'h5,
    S_PEND  = 4'h4,
    S_ESET  = 4'hC,
    S_EPUL  = 4'hD,
    S_EHLD  = 4'hF
  } peb_state_t;

  // Entire module state
  typedef struct packed {
    peb_state_t          st;
    peb_pins_t           pins;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    ptmr;
    logic                rd;
    logic [ADDR_W-1:PAGE_LSB] page;
    logic                in_page;
    logic                last;
    logic [DATA_W-1:0]   wbyte;
    logic [DATA_W-1:0]   rdat;
    logic                rvld;
    logic                perr;
    logic                busy;     // Access, programming or erase running
    logic                rdy;      // Request may be taken
  } peb_reg_t;

  peb_reg_t r;       // Registered state
  peb_reg_t next_r;  // Next state

  // Idle pin values: deselected, outputs off, host not driving
  localparam peb_pins_t PINS_IDLE = '{chip_select_n: 1'b1, output_gate_n: 1'b1, output_gate_hv: 1'b0,
                                      write_strobe_n: 1'b1, addr: '0, data: '0, data_oe: 1'b0};

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.rvld = 1'b0;
    next_r.perr = 1'b0;
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - CNT_ONE;
    end
    // Program timer for the fallback wait
    if (r.ptmr != '0) begin
      next_r.ptmr = r.ptmr - CNT_ONE;
    end
    case (r.st)
      S_IDLE, S_LOAD: begin
        // Page load times out: device starts programming on its own
        if (r.st == S_LOAD && r.cnt == '0) begin
          next_r.st = S_PROG;
          next_r.ptmr = CNT_W'(PROG_CYC);
          next_r.in_page = 1'b0;
        end else if (req_valid_in) begin
          next_r.pins.addr = req_in.addr;
          next_r.last = req_in.last;
          next_r.pins.chip_select_n = 1'b0;
          case (req_in.cmd)
            PEB_CMD_WRITE: begin
              // Refuse a byte from another page; the load stays open
              if (r.in_page && req_in.addr[ADDR_W-1:PAGE_LSB] != r.page) begin
                next_r.perr = 1'b1;
                next_r.pins = PINS_IDLE;
                next_r.pins.addr = r.pins.addr; // Keep last byte address for polling
              end else begin
                // Drive data, keep OE high for the whole write
                next_r.pins.output_gate_n = 1'b1;
                next_r.pins.data = req_in.data;
                next_r.pins.data_oe = 1'b1;
                next_r.page = req_in.addr[ADDR_W-1:PAGE_LSB];
                next_r.in_page = 1'b1;
                next_r.wbyte = req_in.data;
                next_r.st = S_SETUP;
              end
            end
            PEB_CMD_ERASE: begin
              // Erase: select, high voltage on OE, setup delay
              next_r.pins.output_gate_hv = 1'b1;
              next_r.pins.data_oe = 1'b0;
              next_r.cnt = CNT_W'(SH_CYC);
              next_r.st = S_ESET;
            end
            default: begin
              // Read or poll: host floats data, OE low, WE high
              next_r.pins.output_gate_n = 1'b0;
              next_r.pins.data_oe = 1'b0;
              next_r.rd = 1'b1;
              next_r.cnt = CNT_W'(ACC_CYC);
              next_r.st = (req_in.cmd == PEB_CMD_POLL) ? S_POLL : S_STRB;
            end
          endcase
        end
      end
      S_SETUP: begin
        // Address set up; drop WE, device takes address on this fall
        next_r.pins.write_strobe_n = 1'b0;
        next_r.cnt = CNT_W'(WP_CYC);
        next_r.st = S_STRB;
      end
      S_STRB: begin
        if (r.cnt == '0) begin
          if (r.rd) begin
            next_r.rdat = data_in;
            next_r.rvld = 1'b1;
            next_r.rd = 1'b0;
            next_r.pins = PINS_IDLE;
            next_r.st = S_IDLE;
          end else begin
            // Raise WE first; data latched on this rise, held a cycle
            next_r.pins.write_strobe_n = 1'b1;
            next_r.st = S_REL;
          end
        end
      end
      S_REL: begin
        next_r.pins = PINS_IDLE;
        // Address kept so polling reads the last byte written
        next_r.pins.addr = r.pins.addr;
        next_r.cnt = CNT_W'(LOADWIN_CYC);
        next_r.st = r.last ? S_PROG : S_LOAD;
        if (r.last) begin
          next_r.ptmr = CNT_W'(PROG_CYC);
          next_r.in_page = 1'b0;
        end
      end
      S_PROG: begin
        // Poll the last written byte until programming ends
        next_r.pins.addr = {r.page, r.pins.addr[PAGE_LSB-1:0]};
        next_r.pins.chip_select_n = 1'b0;
        next_r.pins.output_gate_n = 1'b0;
        next_r.cnt = CNT_W'(ACC_CYC);
        next_r.st = S_POLL;
      end
      S_POLL: begin
        if (r.cnt == '0) begin
          next_r.pins = PINS_IDLE;
          next_r.pins.addr = r.pins.addr;
          // Done when true bit 7 returns or the program time ran out; a poll request ends after one read
          if (r.rd || data_in[MSB_BIT] == r.wbyte[MSB_BIT] || r.ptmr == '0) begin
            next_r.st = S_PEND;
            if (r.rd) begin
              // Poll request hands back the byte it read
              next_r.rdat = data_in;
              next_r.rvld = 1'b1;
              next_r.rd = 1'b0;
            end
          end else begin
            next_r.st = S_PROG;
          end
        end
      end
      S_PEND: begin
        // One idle cycle to let outputs float; floating lines never reach read data
        next_r.pins = PINS_IDLE;
        next_r.st = S_IDLE;
      end
      S_ESET: begin
        if (r.cnt == '0) begin
          next_r.pins.write_strobe_n = 1'b0;
          next_r.cnt = CNT_W'(ERASE_CYC);
          next_r.st = S_EPUL;
        end
      end
      S_EPUL: begin
        if (r.cnt == '0) begin
          next_r.pins.write_strobe_n = 1'b1;
          next_r.cnt = CNT_W'(SH_CYC);
          next_r.st = S_EHLD;
        end
      end
      S_EHLD: begin
        if (r.cnt == '0) begin
          next_r.pins = PINS_IDLE;
          next_r.st = S_IDLE;
        end
      end
      default: begin
        next_r.pins = PINS_IDLE;
        next_r.st = S_IDLE;
      end
    endcase
    // Busy and ready registered so the outputs come from flip-flops
    next_r.busy = (next_r.st != S_IDLE) && (next_r.st != S_LOAD);
    next_r.rdy = !next_r.busy;
  end

  // State register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r <= '{st: S_IDLE, pins: PINS_IDLE, rdy: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign pins_out      = r.pins;
  assign rd_data_out   = r.rdat;
  assign rd_valid_out  = r.rvld;
  assign page_err_out  = r.perr;
  assign busy_out      = r.busy;
  assign req_ready_out = r.rdy;

  // Host never drives data while the device may drive it
  AST_NO_CONTENTION: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!r.pins.output_gate_n && !r.pins.chip_select_n) |-> !r.pins.data_oe)
    else $error("data driven during read");
  // A write strobe only with OE high and CE low
  AST_WRITE_QUAL: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !r.pins.write_strobe_n |-> (r.pins.output_gate_n && !r.pins.chip_select_n))
    else $error("write strobe outside write mode");
  // OE stays high for three cycles from the fall of a page-write strobe
  AST_OE_HIGH_WRITE: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(r.pins.write_strobe_n) && !r.pins.output_gate_hv |-> r.pins.output_gate_n [*3])
    else $error("output gate low during page write");
  // Write pulse lasts at least its minimum width
  AST_WP_WIDTH: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(r.pins.write_strobe_n) |-> !r.pins.write_strobe_n [*3])
    else $error("write pulse too short");
  // Data holds one cycle past the rising strobe
  AST_DATA_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(r.pins.write_strobe_n) && !r.pins.output_gate_hv |-> r.pins.data_oe && $stable(r.pins.data))
    else $error("data not held after strobe");
  // A byte for another page is refused while loading; the load stays open
  AST_PAGE_KEEP: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (r.st == S_LOAD && r.cnt != '0 && req_valid_in && req_in.cmd == PEB_CMD_WRITE &&
     req_in.addr[ADDR_W-1:PAGE_LSB] != r.page) |=> (r.perr && r.pins.chip_select_n && r.st == S_LOAD))
    else $error("page address changed");
  // Load window expiry leads to programming
  AST_LOAD_WIN: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (r.st == S_LOAD && r.cnt == '0) |=> (r.st == S_PROG))
    else $error("load window not honoured");
  // Erase keeps data floating with high voltage on OE
  AST_ERASE: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (r.st == S_EPUL) |-> (r.pins.output_gate_hv && !r.pins.chip_select_n && !r.pins.data_oe))
    else $error("erase pins wrong");
  // No new request accepted while programming
  AST_BUSY: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (r.st == S_PROG || r.st == S_POLL) |-> (!req_ready_out && busy_out))
    else $error("ready while programming");
endmodule : peb_host

// >>> verilog/peb_pkg.sv
// Package with constants and carrier types for the parallel EEPROM host controller
package peb_pkg;
  // Clock rate in kHz and period in ns
  localparam int CLK_KHZ        = 25000;
  localparam int CLK_NS         = 40;
  // Bus widths
  localparam int ADDR_W         = 13;
  localparam int DATA_W         = 8;
  localparam int PAGE_LSB       = 6;
  localparam int MSB_BIT        = 7;
  localparam int TOG_BIT        = 6;
  // Pin timing in ns, rounded up to whole cycles, access one cycle more
  localparam int WP_NS          = 100;
  localparam int WP_CYC         = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_NS         = 150;
  localparam int ACC_CYC        = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
  // Byte load window in us, longest time, halved for margin
  localparam int LOADWIN_US     = 150;
  localparam int LOADWIN_CYC    = LOADWIN_US * (CLK_KHZ / 1000) / 2;
  // Internal program time in ms
  localparam int PROG_MS        = 10;
  localparam int PROG_CYC       = PROG_MS * CLK_KHZ;
  // Chip erase pulse and setup/hold
  localparam int ERASE_MS       = 10;
  localparam int ERASE_CYC      = ERASE_MS * CLK_KHZ;
  localparam int SH_US          = 1;
  localparam int SH_CYC         = SH_US * (CLK_KHZ / 1000);
  localparam int CNT_W          = 20;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

  // Commands
  typedef enum logic [1:0] {
    PEB_CMD_READ  = 2'h0,
    PEB_CMD_WRITE = 2'h1,
    PEB_CMD_ERASE = 2'h2,
    PEB_CMD_POLL  = 2'h3
  } peb_cmd_t;

  // Host request
  typedef struct packed {
    peb_cmd_t          cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              last;
  } peb_req_t;

  // Pins toward the device
  typedef struct packed {
    logic              chip_select_n;
    logic              output_gate_n;
    logic              output_gate_hv;
    logic              write_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              data_oe;
  } peb_pins_t;
endpackage : peb_pkg
